/* bench/fss_partner.sv */
`timescale 1ns/1ps
`default_nettype none
// ****
// sample source and sink
// ****
module fss_partner (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // source pacing
    input wire logic src_en,
    input wire logic [7:0] src_gap,
    // input stream
    output logic tvalid,
    input wire logic tready,
    output logic [fss_pkg::DATA_W-1:0] tdata,
    // output stream
    input wire logic out_valid,
    input wire logic [fss_pkg::DATA_W-1:0] out_data,
    input wire logic [fss_pkg::CHAN_W-1:0] out_chan
);
    int cyc;
    int n_sent;
    int wait_n;
    int acc_t[$];
    int out_t[$];
    logic [fss_pkg::DATA_W-1:0] out_d[$];
    logic [fss_pkg::CHAN_W-1:0] out_c[$];
    logic hs;
    logic v;
    // sampled on the falling edge, clear of the design's own updates
    always @(negedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cyc = 0;
            hs = 1'b0;
            acc_t.delete();
            out_t.delete();
            out_d.delete();
            out_c.delete();
        end else begin
            cyc = cyc + 1;
            hs = tvalid && tready;
            if (hs) begin
                acc_t.push_back(cyc);
            end
            // no ready on the sink: every pulse is taken
            if (out_valid) begin
                out_t.push_back(cyc);
                out_d.push_back(out_data);
                out_c.push_back(out_chan);
            end
        end
    end
    // word held until taken; idle data toggles so a stale word never matches
    initial begin
        tvalid = 1'b0;
        tdata = 16'h0100;
        n_sent = 0;
        wait_n = 0;
        forever begin
            @(posedge clk);
            #1;
            v = tvalid;
            if (!reset_n) begin
                v = 1'b0;
                n_sent = 0;
                wait_n = 0;
            end else begin
                if (hs) begin
                    n_sent = n_sent + 1;
                    wait_n = src_gap;
                    v = 1'b0;
                end
                if (!v && wait_n > 0) begin
                    wait_n = wait_n - 1;
                end else if (!v && src_en) begin
                    v = 1'b1;
                end
            end
            tvalid = v;
            tdata = v ? 16'h0100 + n_sent[15:0] : ~tdata;
        end
    end
endmodule
`default_nettype wire

/* bench/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic clk;
    logic reset_n;
    fss_pkg::fss_mode_t mode;
    logic use_p, fifo_en, s_valid, s_ready, m_valid, src_en;
    logic [fss_pkg::CNT_W-1:0] period, clk_mhz, fs_mhz, rate_p, rate_q, osr;
    logic [fss_pkg::CHAN_W-1:0] chans, m_chan;
    logic [fss_pkg::DATA_W-1:0] s_data, m_data;
    logic [7:0] src_gap;
    int n_mismatch, n_tests, cycles;
    // ****
    // design and partner
    // ****
    fss_scheduler dut (
        .CLK(clk), .RESET_N(reset_n), .CFG_MODE(mode), .CFG_USE_PERIOD(use_p),
        .CFG_PERIOD(period), .CFG_CLK_MHZ(clk_mhz), .CFG_FS_MHZ(fs_mhz),
        .CFG_RATE_P(rate_p), .CFG_RATE_Q(rate_q), .CFG_CHANNELS(chans),
        .CFG_FIFO_EN(fifo_en), .S_AXIS_DATA_TVALID(s_valid), .S_AXIS_DATA_TREADY(s_ready),
        .S_AXIS_DATA_TDATA(s_data), .M_AXIS_DATA_TVALID(m_valid),
        .M_AXIS_DATA_TDATA(m_data), .M_AXIS_DATA_TCHAN(m_chan), .OVERSAMPLE(osr)
    );
    fss_partner p (
        .clk(clk), .reset_n(reset_n), .src_en(src_en), .src_gap(src_gap),
        .tvalid(s_valid), .tready(s_ready), .tdata(s_data),
        .out_valid(m_valid), .out_data(m_data), .out_chan(m_chan)
    );
    // ****
    // helpers
    // ****
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // config only changes under reset, so the design never sees it move
    task automatic setup(input fss_pkg::fss_mode_t m, input logic up, input logic [15:0] per,
                         input logic [15:0] rp, input logic [15:0] rq, input logic [3:0] ch,
                         input logic fe, input logic [7:0] gap);
        @(posedge clk);
        #1;
        reset_n = 1'b0;
        src_en = 1'b0;
        mode = m;
        {use_p, period, rate_p, rate_q, chans, fifo_en, src_gap} = {up, per, rp, rq, ch, fe, gap};
        repeat (2) @(posedge clk);
        #1;
        reset_n = 1'b1;
        src_en = 1'b1;
    endtask
    task automatic gaps(input int pat[5], input int n, input int from, input int cnt);
        check("output count", p.out_t.size() > from + cnt, 1);
        for (int i = from; i < from + cnt; i++) begin
            check("output gap", p.out_t[i + 1] - p.out_t[i], pat[(i - from) % n]);
        end
    endtask
    // ****
    // scenarios
    // ****
    task automatic t_single;
        setup(fss_pkg::FSS_SINGLE, 1'b1, 4, 1, 1, 1, 1'b1, 0);
        repeat (60) @(posedge clk);
        check("burst accept", p.acc_t[3] - p.acc_t[0], 3);
        check("paced accept", p.acc_t[10] - p.acc_t[9], 4);
        check("data order", p.out_d[2], 16'h0102);
        gaps('{4, 4, 4, 4, 4}, 1, 1, 8);
    endtask
    task automatic t_decim;
        setup(fss_pkg::FSS_INT_DECIM, 1'b0, 0, 1, 3, 1, 1'b1, 3);
        repeat (100) @(posedge clk);
        check("oversample", osr, 4);
        gaps('{12, 12, 12, 12, 12}, 1, 1, 4);
    endtask
    task automatic t_interp;
        setup(fss_pkg::FSS_INT_INTERP, 1'b1, 8, 3, 1, 1, 1'b1, 7);
        repeat (70) @(posedge clk);
        gaps('{2, 2, 4, 0, 0}, 3, 0, 6);
    endtask
    task automatic t_frac5;
        setup(fss_pkg::FSS_FRAC_INTERP, 1'b1, 4, 5, 3, 1, 1'b1, 3);
        repeat (60) @(posedge clk);
        gaps('{2, 2, 2, 2, 4}, 5, 0, 10);
        check("five in twelve", p.out_t[5] - p.out_t[0], 12);
    endtask
    task automatic t_frac3;
        setup(fss_pkg::FSS_FRAC_INTERP, 1'b1, 3, 5, 3, 1, 1'b0, 0);
        repeat (50) @(posedge clk);
        check("request rate", p.acc_t[3] - p.acc_t[2], 2);
        gaps('{1, 1, 1, 1, 2}, 5, 0, 10);
    endtask
    task automatic t_fdec;
        setup(fss_pkg::FSS_FRAC_DECIM, 1'b1, 6, 3, 5, 1, 1'b1, 0);
        repeat (80) @(posedge clk);
        check("full rate fill", p.acc_t[7] - p.acc_t[0], 7);
        gaps('{6, 6, 6, 6, 6}, 1, 2, 6);
    endtask
    task automatic t_tdm;
        setup(fss_pkg::FSS_SINGLE, 1'b1, 8, 1, 1, 4, 1'b1, 1);
        repeat (40) @(posedge clk);
        check("oversample", osr, 2);
        for (int i = 0; i < 6; i++) begin
            check("channel", p.out_c[i], i % 4);
        end
        gaps('{2, 2, 2, 2, 2}, 1, 1, 5);
    endtask
    // ****
    // run
    // ****
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // ceiling well above the roughly 500 cycles the scenarios need
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            n_mismatch++;
            complete_run();
        end
    end
    initial begin
        reset_n = 1'b0;
        src_en = 1'b0;
        src_gap = 8'h00;
        mode = fss_pkg::FSS_SINGLE;
        {use_p, fifo_en, period, rate_p, rate_q, chans} = '0;
        clk_mhz = 16'h00C8;
        fs_mhz = 16'h0032;
        repeat (2) @(posedge clk);
        #1;
        reset_n = 1'b1;
        t_single();
        t_decim();
        t_interp();
        t_frac5();
        t_frac3();
        t_fdec();
        t_tdm();
        complete_run();
    end
endmodule
`default_nettype wire

/* hdl/fss_fifo.sv */
`timescale 1ns/1ps
`default_nettype none
module fss_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 4
) (
    // clock and reset
    input wire logic CLK,
    input wire logic RESET_N,
    // fill side
    input wire logic IN_VALID,
    output logic IN_READY,
    input wire logic [WIDTH-1:0] IN_DATA,
    // drain side
    output logic OUT_VALID,
    input wire logic OUT_READY,
    output logic [WIDTH-1:0] OUT_DATA
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] LAST = (AW + 1)'(DEPTH - 1);
    localparam logic [AW:0] FULL = (AW + 1)'(DEPTH);

    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [AW-1:0] wr_ff, nxt_wr, rd_ff, nxt_rd;
    logic [AW:0] cnt_ff, nxt_cnt;
    logic push, pop;

    assign IN_READY = (cnt_ff != FULL);
    assign OUT_VALID = (cnt_ff != '0);
    assign OUT_DATA = mem_ff[rd_ff];

    always_comb begin
        push = IN_VALID && IN_READY;
        pop = OUT_VALID && OUT_READY;
        nxt_wr = wr_ff;
        nxt_rd = rd_ff;
        nxt_cnt = cnt_ff;
        if (push) begin
            nxt_wr = ({1'b0, wr_ff} == LAST) ? '0 : wr_ff + 1'b1;
        end
        if (pop) begin
            nxt_rd = ({1'b0, rd_ff} == LAST) ? '0 : rd_ff + 1'b1;
        end
        if (push && !pop) begin
            nxt_cnt = cnt_ff + 1'b1;
        end else if (pop && !push) begin
            nxt_cnt = cnt_ff - 1'b1;
        end
    end

    // storage has no reset; contents are only read when counted valid
    always_ff @(posedge CLK) begin
        if (push) begin
            mem_ff[wr_ff] <= IN_DATA;
        end
    end

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            wr_ff <= '0;
            rd_ff <= '0;
            cnt_ff <= '0;
        end else begin
            wr_ff <= nxt_wr;
            rd_ff <= nxt_rd;
            cnt_ff <= nxt_cnt;
        end
    end
endmodule
`default_nettype wire

/* hdl/fss_pkg.sv */
// Summary of operation
// - cycles per input come from clock/sample frequency ratio or a given sample period.
// - integer rate change: fixed input slots; decimated output period is input period times M.
// - integer interpolation uses floored output spacing, idling the leftover cycles.
// - fractional interpolation spacing is input period over worst-case outputs per input.
// - five-over-three interpolation yields output counts two, two, one per input.
// - spacing rounds down and input ready is raised at the matching faster rate.
// - fractional decimation outputs at the output period once enough inputs arrived.
// - fractional decimation takes one input per clock until its buffer is full.
// - input FIFO accepts at full rate until full; core drains once per input slot, or once per clock in fractional decimation.
// - channels are time multiplexed on one input; oversampling is period over channels.
`default_nettype none
package fss_pkg;
    localparam int DATA_W = 16;
    localparam int CNT_W = 16;
    localparam int CHAN_W = 4;
    localparam int FIFO_DEPTH = 4;
    localparam int BUF_DEPTH = 8;
    localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
    localparam logic [CNT_W-1:0] CNT_MAX = 16'hFFFF;
    localparam logic [CNT_W-1:0] BUF_FULL = 16'h0008;
    localparam logic [CHAN_W-1:0] CHAN_ONE = 4'h1;

    typedef enum logic [2:0] {
        FSS_SINGLE,
        FSS_INT_INTERP,
        FSS_INT_DECIM,
        FSS_FRAC_INTERP,
        FSS_FRAC_DECIM
    } fss_mode_t;

    typedef enum logic {
        FSS_WAIT,
        FSS_EMIT
    } fss_state_t;
endpackage
`default_nettype wire

/* hdl/fss_scheduler.sv */
`timescale 1ns/1ps
`default_nettype none
module fss_scheduler (
    // clock and reset
    input wire logic CLK,
    input wire logic RESET_N,
    // configuration
    input wire fss_pkg::fss_mode_t CFG_MODE,
    input wire logic CFG_USE_PERIOD,
    input wire logic [fss_pkg::CNT_W-1:0] CFG_PERIOD,
    input wire logic [fss_pkg::CNT_W-1:0] CFG_CLK_MHZ,
    input wire logic [fss_pkg::CNT_W-1:0] CFG_FS_MHZ,
    input wire logic [fss_pkg::CNT_W-1:0] CFG_RATE_P,
    input wire logic [fss_pkg::CNT_W-1:0] CFG_RATE_Q,
    input wire logic [fss_pkg::CHAN_W-1:0] CFG_CHANNELS,
    input wire logic CFG_FIFO_EN,
    // input sample stream
    input wire logic S_AXIS_DATA_TVALID,
    output logic S_AXIS_DATA_TREADY,
    input wire logic [fss_pkg::DATA_W-1:0] S_AXIS_DATA_TDATA,
    // output sample stream
    output logic M_AXIS_DATA_TVALID,
    output logic [fss_pkg::DATA_W-1:0] M_AXIS_DATA_TDATA,
    output logic [fss_pkg::CHAN_W-1:0] M_AXIS_DATA_TCHAN,
    // status
    output logic [fss_pkg::CNT_W-1:0] OVERSAMPLE
);
    localparam int CW = fss_pkg::CNT_W;

    // floored division, never below one cycle, divide by zero yields the dividend
    function automatic logic [CW-1:0] fss_div(input logic [CW-1:0] a, input logic [CW-1:0] b);
        logic [CW-1:0] q;
        q = (b == '0) ? a : a / b;
        return (q == '0) ? fss_pkg::CNT_ONE : q;
    endfunction

    // ************************************************************
    // rate arithmetic
    // ************************************************************
    logic [CW-1:0] cpi, os, rp, rq, wmax, spc, slot, out_per, need;
    logic [2*CW-1:0] slot_w, oper_w;
    logic [CW:0] psum;

    always_comb begin
        cpi = CFG_USE_PERIOD ? fss_div(CFG_PERIOD, fss_pkg::CNT_ONE)
                             : fss_div(CFG_CLK_MHZ, CFG_FS_MHZ);
        os = fss_div(cpi, {{(CW - fss_pkg::CHAN_W){1'b0}}, CFG_CHANNELS});
        rp = fss_div(CFG_RATE_P, fss_pkg::CNT_ONE);
        rq = fss_div(CFG_RATE_Q, fss_pkg::CNT_ONE);
        if (CFG_MODE == fss_pkg::FSS_SINGLE) begin
            rp = fss_pkg::CNT_ONE;
            rq = fss_pkg::CNT_ONE;
        end else if (CFG_MODE == fss_pkg::FSS_INT_INTERP) begin
            rq = fss_pkg::CNT_ONE;
        end
        psum = {1'b0, rp} + {1'b0, rq} - 1'b1;
        wmax = fss_div(psum[CW-1:0], rq); // worst-case outputs per input
        spc = fss_div(os, wmax);
        slot_w = spc * wmax;
        // fractional interpolation asks early; integer keeps the full slot
        slot = (CFG_MODE == fss_pkg::FSS_FRAC_INTERP) ? slot_w[CW-1:0] : os;
        oper_w = os * rq;
        out_per = CFG_USE_PERIOD ? os : fss_div(oper_w[CW-1:0], rp);
    end

    // ************************************************************
    // state
    // ************************************************************
    fss_pkg::fss_state_t st_ff, nxt_st;
    logic [CW-1:0] tmr_ff, nxt_tmr, spcnt_ff, nxt_spcnt, ph_ff, nxt_ph;
    logic [CW-1:0] dcnt_ff, nxt_dcnt, otmr_ff, nxt_otmr, buf_ff, nxt_buf;
    logic [fss_pkg::CHAN_W-1:0] chan_ff, nxt_chan, ochan_ff, nxt_ochan;
    logic [fss_pkg::DATA_W-1:0] smp_ff, nxt_smp;
    logic ov_ff, nxt_ov;
    logic want, req, emit, take, f_iv, f_ir, f_ov;
    logic [fss_pkg::DATA_W-1:0] f_od;
    logic [CW:0] phq;

    // ************************************************************
    // input handshake
    // ************************************************************
    always_comb begin
        // ask one cycle ahead, so the word has landed when the slot opens
        req = ({1'b0, tmr_ff} + {1'b0, fss_pkg::CNT_ONE} >= {1'b0, slot - 1'b1});
        case (CFG_MODE)
            fss_pkg::FSS_FRAC_DECIM: begin
                want = (buf_ff < fss_pkg::BUF_FULL);
                req = want;
            end
            fss_pkg::FSS_INT_DECIM: want = (tmr_ff >= slot - 1'b1);
            default: want = (st_ff == fss_pkg::FSS_WAIT) && (tmr_ff >= slot - 1'b1);
        endcase
        take = want && f_ov;
        // without the fifo option the source is only let in when the core asks;
        // a word may enter as the held one leaves, keeping one per clock
        S_AXIS_DATA_TREADY = f_ir && (CFG_FIFO_EN || (req && (!f_ov || take)));
        f_iv = S_AXIS_DATA_TVALID && S_AXIS_DATA_TREADY;
    end

    fss_fifo #(
        .WIDTH(fss_pkg::DATA_W),
        .DEPTH(fss_pkg::FIFO_DEPTH)
    ) u_fifo (
        .CLK(CLK),
        .RESET_N(RESET_N),
        .IN_VALID(f_iv),
        .IN_READY(f_ir),
        .IN_DATA(S_AXIS_DATA_TDATA),
        .OUT_VALID(f_ov),
        .OUT_READY(take),
        .OUT_DATA(f_od)
    );

    // ************************************************************
    // scheduler
    // ************************************************************
    always_comb begin
        nxt_st = st_ff;
        nxt_tmr = (tmr_ff != fss_pkg::CNT_MAX) ? tmr_ff + 1'b1 : tmr_ff;
        nxt_spcnt = spcnt_ff;
        nxt_ph = ph_ff;
        nxt_dcnt = dcnt_ff;
        nxt_otmr = otmr_ff;
        nxt_buf = buf_ff;
        nxt_chan = chan_ff;
        nxt_ochan = ochan_ff;
        nxt_smp = smp_ff;
        nxt_ov = 1'b0;
        emit = 1'b0;
        need = fss_pkg::CNT_ONE;
        phq = {1'b0, ph_ff} + {1'b0, rq};
        if (take) begin
            nxt_tmr = '0;
            nxt_smp = f_od;
            nxt_ochan = chan_ff;
            nxt_chan = (chan_ff + fss_pkg::CHAN_ONE >= CFG_CHANNELS) ? '0
                                                                   : chan_ff + fss_pkg::CHAN_ONE;
        end
        case (CFG_MODE)
            fss_pkg::FSS_FRAC_DECIM: begin
                need = fss_div(phq[CW-1:0], rp);
                nxt_buf = take ? buf_ff + 1'b1 : buf_ff;
                if (otmr_ff < out_per - 1'b1) begin
                    nxt_otmr = otmr_ff + 1'b1;
                end else if (buf_ff >= need) begin
                    // output only once enough inputs are buffered
                    nxt_ov = 1'b1;
                    nxt_buf = nxt_buf - need;
                    nxt_ph = phq[CW-1:0] - CW'(need * rp);
                    nxt_otmr = '0;
                end
            end
            fss_pkg::FSS_INT_DECIM: begin
                if (take) begin
                    if (dcnt_ff >= rq - 1'b1) begin
                        nxt_ov = 1'b1;
                        nxt_dcnt = '0;
                    end else begin
                        nxt_dcnt = dcnt_ff + 1'b1;
                    end
                end
            end
            default: begin
                case (st_ff)
                    // first output leaves with the take, so a burst ends
                    // before the next slot even at a spacing of one
                    fss_pkg::FSS_WAIT: emit = take;
                    fss_pkg::FSS_EMIT: begin
                        emit = (spcnt_ff == '0);
                        nxt_spcnt = spcnt_ff - 1'b1;
                    end
                    default: nxt_st = fss_pkg::FSS_WAIT;
                endcase
                if (emit) begin
                    nxt_ov = 1'b1;
                    nxt_spcnt = spc - 1'b1;
                    // phase walk gives 2,2,1 for 5 over 3
                    if (phq >= {1'b0, rp}) begin
                        nxt_ph = phq[CW-1:0] - rp;
                        nxt_st = fss_pkg::FSS_WAIT;
                    end else begin
                        nxt_ph = phq[CW-1:0];
                        nxt_st = fss_pkg::FSS_EMIT;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            st_ff <= fss_pkg::FSS_WAIT;
            tmr_ff <= fss_pkg::CNT_MAX;
            spcnt_ff <= '0;
            ph_ff <= '0;
            dcnt_ff <= '0;
            otmr_ff <= '0;
            buf_ff <= '0;
            chan_ff <= '0;
            ochan_ff <= '0;
            smp_ff <= '0;
            ov_ff <= 1'b0;
        end else begin
            st_ff <= nxt_st;
            tmr_ff <= nxt_tmr;
            spcnt_ff <= nxt_spcnt;
            ph_ff <= nxt_ph;
            dcnt_ff <= nxt_dcnt;
            otmr_ff <= nxt_otmr;
            buf_ff <= nxt_buf;
            chan_ff <= nxt_chan;
            ochan_ff <= nxt_ochan;
            smp_ff <= nxt_smp;
            ov_ff <= nxt_ov;
        end
    end

    assign M_AXIS_DATA_TVALID = ov_ff;
    assign M_AXIS_DATA_TDATA = smp_ff;
    assign M_AXIS_DATA_TCHAN = ochan_ff;
    assign OVERSAMPLE = os;

    // ************************************************************
    // checks
    // ************************************************************
    logic [CW-1:0] emits_ff;
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            emits_ff <= '0;
        end else if (take) begin
            emits_ff <= nxt_ov ? fss_pkg::CNT_ONE : '0;
        end else if (nxt_ov) begin
            emits_ff <= emits_ff + 1'b1;
        end
    end

    AST_PERIOD_SRC: assert property (@(posedge CLK) disable iff (!RESET_N)
        CFG_USE_PERIOD && CFG_PERIOD != '0 |-> cpi == CFG_PERIOD)
        else $error("period source not used");
    AST_INT_SLOT: assert property (@(posedge CLK) disable iff (!RESET_N)
        take && CFG_MODE != fss_pkg::FSS_FRAC_DECIM |-> tmr_ff >= slot - 1'b1)
        else $error("input taken before its slot");
    AST_DECIM_OUT: assert property (@(posedge CLK) disable iff (!RESET_N)
        CFG_MODE == fss_pkg::FSS_INT_DECIM && M_AXIS_DATA_TVALID |-> $past(take))
        else $error("decimated output without input");
    AST_INTERP_FIRST: assert property (@(posedge CLK) disable iff (!RESET_N)
        CFG_MODE == fss_pkg::FSS_INT_INTERP && take |=> M_AXIS_DATA_TVALID)
        else $error("first interpolated output late");
    AST_SPACING: assert property (@(posedge CLK) disable iff (!RESET_N)
        CFG_MODE == fss_pkg::FSS_FRAC_INTERP && M_AXIS_DATA_TVALID && spc > fss_pkg::CNT_ONE
        |=> !M_AXIS_DATA_TVALID)
        else $error("outputs closer than spacing");
    AST_WORST_CASE: assert property (@(posedge CLK) disable iff (!RESET_N)
        CFG_MODE == fss_pkg::FSS_FRAC_INTERP |-> emits_ff <= wmax)
        else $error("too many outputs for one input");
    AST_BUF_LIMIT: assert property (@(posedge CLK) disable iff (!RESET_N)
        buf_ff <= fss_pkg::BUF_FULL)
        else $error("decimation buffer overrun");
    AST_FIFO_FULL: assert property (@(posedge CLK) disable iff (!RESET_N)
        CFG_FIFO_EN && !S_AXIS_DATA_TREADY |-> u_fifo.cnt_ff == fss_pkg::FIFO_DEPTH)
        else $error("ready low before fifo full");
    AST_DECIM_GAP: assert property (@(posedge CLK) disable iff (!RESET_N)
        CFG_MODE == fss_pkg::FSS_FRAC_DECIM && M_AXIS_DATA_TVALID && out_per > fss_pkg::CNT_ONE
        |=> !M_AXIS_DATA_TVALID)
        else $error("decimated outputs too close");
endmodule
`default_nettype wire
